/* bench/mem_model.sv */
// Memory side: loops the divider reset back late, returns last word.
// Assumes one write is read back before the next write.
`timescale 1ns/1ps
module mem_model (
  input wire logic CLK,
  input wire logic drive,
  input wire logic write_en,
  input wire logic [memsys_pkg::DATA_W-1:0] dq_out,
  input wire logic corrupt,
  output logic ret,
  output logic [memsys_pkg::DATA_W-1:0] dq_in
);
  logic [memsys_pkg::DATA_W-1:0] word = 8'h00; // Last word written.
  int cnt = 0; // Cycles since the drive pulse; 0 when idle.
  initial begin
    ret = 1'b0;
    dq_in = 8'h00;
  end
  always @(posedge CLK) begin
    if (write_en) begin
      word <= dq_out;
    end
    cnt <= drive ? 1 : (cnt == 0 || cnt == 20) ? 0 : cnt + 1;
    ret <= cnt >= 6 && cnt < 14;
    // Data settle before the return edge; released, they toggle.
    dq_in <= (cnt >= 2 && cnt < 16) ? word ^ {8{corrupt}} : ~dq_in;
  end
endmodule : mem_model

/* bench/memsys_asserts.sv */
// Port checker for the memory system interface top.
// Assumes one clock domain: CLK, reset by RST.
`timescale 1ns/1ps
module memsys_asserts (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic READ_VALID_OUT,
  input wire logic INIT_COMPLETE_OUT,
  input wire logic MISMATCH_ERROR_OUT,
  input wire logic WORK_CLOCK_OUT,
  input wire logic WORK_CLOCK_N_OUT,
  input wire logic STROBE_DIV_RESET_DRIVE,
  input wire logic STROBE_DIV_RESET_RETURN,
  input wire logic [2:0] MEM_CMD,
  input wire logic MEM_CKE,
  input wire logic MEM_WRITE_EN,
  input wire logic [7:0] MEM_DQ_OUT,
  input wire logic MEM_DQ_OE,
  input wire logic MEM_STROBE_OUT,
  input wire logic MEM_STROBE_OE,
  input wire logic MEM_STROBE_COMPLEMENT_OUT,
  input wire logic MEM_MODULE_RESET
);
  // Every check runs on the system clock and sleeps in reset.
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////
  write_cmd_a:
    assert property (WR && ADDR == 4'h5 && INIT_COMPLETE_OUT |=>
      MEM_WRITE_EN && MEM_DQ_OE && MEM_DQ_OUT == $past(WDATA))
    else $error("write stage lost its data");
  wr_align_a:
    assert property (MEM_STROBE_OUT == MEM_WRITE_EN &&
      MEM_STROBE_OE == MEM_WRITE_EN && (!MEM_WRITE_EN || MEM_CMD == 3'h4))
    else $error("write enable apart from command");
  clk_inv_a:
    assert property (WORK_CLOCK_N_OUT != WORK_CLOCK_OUT)
    else $error("inverted clock not inverse");
  drive_pulse_a:
    assert property (STROBE_DIV_RESET_DRIVE == (MEM_CMD == 3'h5))
    else $error("divider reset pulse wrong");
  valid_src_a:
    assert property ($rose(READ_VALID_OUT) |-> $past(STROBE_DIV_RESET_RETURN))
    else $error("capture not timed by return");
  valid_err_a:
    assert property ($rose(MISMATCH_ERROR_OUT) |-> READ_VALID_OUT)
    else $error("error without read valid");
  init_cke_a:
    assert property ($rose(INIT_COMPLETE_OUT) |-> MEM_CKE)
    else $error("init done with clock disabled");
  pins_off_a:
    assert property (!MEM_MODULE_RESET &&
      MEM_STROBE_COMPLEMENT_OUT != MEM_STROBE_OUT)
    else $error("optional pin wrong");
  cover property ($rose(INIT_COMPLETE_OUT));
  cover property ($rose(READ_VALID_OUT));
  cover property ($rose(MISMATCH_ERROR_OUT));
endmodule : memsys_asserts
bind memsys_top memsys_asserts memsys_asserts_inst (.CLK, .RST, .ADDR,
  .WDATA, .WR, .READ_VALID_OUT, .INIT_COMPLETE_OUT, .MISMATCH_ERROR_OUT,
  .WORK_CLOCK_OUT, .WORK_CLOCK_N_OUT, .STROBE_DIV_RESET_DRIVE,
  .STROBE_DIV_RESET_RETURN, .MEM_CMD, .MEM_CKE, .MEM_WRITE_EN,
  .MEM_DQ_OUT, .MEM_DQ_OE, .MEM_STROBE_OUT, .MEM_STROBE_OE,
  .MEM_STROBE_COMPLEMENT_OUT, .MEM_MODULE_RESET);

/* bench/testbench.sv */
// Self-checking bench for the memory system interface top.
// Assumes the default build: clock manager and self-test present.
`timescale 1ns/1ps
module testbench;
  logic CLK, RST, SYS_RESET_IN, SYS_CLOCK_POS, SYS_CLOCK_NEG, EXT_CLOCK;
  logic EXT_LOCK, WR, RD, IRQ, READ_VALID_OUT, INIT_COMPLETE_OUT;
  logic MISMATCH_ERROR_OUT, WORK_CLOCK_OUT, WORK_CLOCK_N_OUT, MEM_CKE;
  logic STROBE_DIV_RESET_DRIVE, STROBE_DIV_RESET_RETURN, MEM_WRITE_EN;
  logic MEM_DQ_OE, MEM_STROBE_OUT, MEM_STROBE_COMPLEMENT_OUT, corrupt;
  logic MEM_STROBE_OE, MEM_MODULE_RESET;
  logic [3:0] ADDR;
  logic [2:0] MEM_CMD;
  logic [memsys_pkg::DATA_W-1:0] WDATA, RDATA, MEM_DQ_OUT, MEM_DQ_IN, v, d;
  int miscompares = 0;
  int tests_run = 0;
  integer seed, i, k;
  memsys_top memsys_top_inst (.CLK, .RST, .SYS_RESET_IN, .SYS_CLOCK_POS,
    .SYS_CLOCK_NEG, .EXT_CLOCK, .EXT_LOCK, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .IRQ, .READ_VALID_OUT, .INIT_COMPLETE_OUT, .MISMATCH_ERROR_OUT,
    .WORK_CLOCK_OUT, .WORK_CLOCK_N_OUT, .STROBE_DIV_RESET_DRIVE,
    .STROBE_DIV_RESET_RETURN, .MEM_CMD, .MEM_CKE, .MEM_WRITE_EN,
    .MEM_DQ_OUT, .MEM_DQ_OE, .MEM_DQ_IN, .MEM_STROBE_OUT,
    .MEM_STROBE_COMPLEMENT_OUT, .MEM_STROBE_OE, .MEM_MODULE_RESET);
  mem_model mem_model_inst (.CLK, .drive(STROBE_DIV_RESET_DRIVE),
    .write_en(MEM_WRITE_EN), .dq_out(MEM_DQ_OUT), .corrupt,
    .ret(STROBE_DIV_RESET_RETURN), .dq_in(MEM_DQ_IN));
  ////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // differential pair, 400 ns, phase unrelated to CLK.
  initial begin
    SYS_CLOCK_POS = 1'b0;
    #13;
    forever #200 SYS_CLOCK_POS = ~SYS_CLOCK_POS;
  end
  assign SYS_CLOCK_NEG = ~SYS_CLOCK_POS;
  // The corrupted word comes back inverted.
  function automatic logic [7:0] expect_word(input logic [7:0] w,
    input logic bad);
    return bad ? ~w : w;
  endfunction : expect_word
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    ADDR <= a;
    WDATA <= x;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 x = RDATA;
    @(posedge CLK);
  endtask : rd
  // Waits, bounded, for init done (0) or read valid (1).
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    while ((which == 0 ? INIT_COMPLETE_OUT : READ_VALID_OUT) !== 1'b1) begin
      @(posedge CLK);
      #1 n++;
      if (n > 6000) begin
        miscompares++;
        summarize();
      end
    end
  endtask : wait_hi
  initial begin
    repeat (100000) @(posedge CLK);
    miscompares++;
    summarize();
  end
  initial begin
    seed = 26748;
    RST = 1'b1;
    // pin high means not in reset.
    SYS_RESET_IN = 1'b1;
    // outside clock and lock, unused with the manager.
    EXT_CLOCK = 1'b0;
    EXT_LOCK = 1'b0;
    ADDR = 4'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    corrupt = 1'b0;
    v = 8'h00;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    for (i = 0; i < 60 && v[memsys_pkg::ST_LOCK] !== 1'b1; i++) begin
      repeat (4) @(posedge CLK);
      rd(memsys_pkg::REG_STATUS, v);
    end
    chk(8'(v[memsys_pkg::ST_LOCK]), 8'h01);
    repeat (8) @(posedge CLK);
    wr(memsys_pkg::REG_CTRL, 8'h01);
    wait_hi(0);
    chk(8'(IRQ), 8'h00);
    wr(memsys_pkg::REG_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge CLK);
    chk(8'(IRQ), 8'h01);
    wr(memsys_pkg::REG_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge CLK);
    chk(8'(IRQ), 8'h00);
    rd(4'hf, v);
    chk(v, 8'h00);
    for (k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      corrupt <= (k == 3);
      wr(memsys_pkg::REG_WRITE_DATA, d);
      chk(MEM_DQ_OUT, d);
      wr(memsys_pkg::REG_CTRL, 8'h04);
      wr(memsys_pkg::REG_CTRL, 8'h02);
      wait_hi(1);
      repeat (2) @(posedge CLK);
      #1 chk(8'(MISMATCH_ERROR_OUT), 8'(k == 3));
      rd(memsys_pkg::REG_READ_DATA, v);
      chk(v, expect_word(d, corrupt));
      repeat (2) @(posedge CLK);
      #1 chk(8'(READ_VALID_OUT), 8'h00);
    end
    // low pin resets the core mid-run.
    SYS_RESET_IN <= 1'b0;
    repeat (6) @(posedge CLK);
    #1 chk(8'({INIT_COMPLETE_OUT, MISMATCH_ERROR_OUT}), 8'h00);
    SYS_RESET_IN <= 1'b1;
    summarize();
  end
endmodule : testbench

/* rtl/clock_reset_gen.sv */
// Clock and reset generation for the memory system interface.
// Assumes pins from outside the domain; they are synchronised here.
`timescale 1ns/1ps
module clock_reset_gen #(
  parameter bit USE_MANAGER = 1'b1,
  parameter bit RESET_ACTIVE_LOW = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sys_reset_in,
  input wire logic sys_clock_pos,
  input wire logic sys_clock_neg,
  input wire logic ext_clock,
  input wire logic ext_lock,
  output logic work_clock,
  output logic work_clock_n,
  output logic locked,
  output logic int_reset
);

  // Two-stage synchronisers, one bit per pin.
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic buf_clock_prev; // Last buffered clock level.
  logic [4:0] edge_count; // Rising edges seen by the manager.

  ////////////////////////////////////////////////////////////////////////
  // Synchronise every pin before any logic reads it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {sys_reset_in, sys_clock_pos, sys_clock_neg,
        ext_clock, ext_lock};
      sync_b <= sync_a;
    end
  end

  // The differential buffer sees a one only when the pair disagrees
  // the right way, which rejects common-mode glitches.
  logic buf_clock;
  logic src_clock;
  logic reset_level;
  always_comb begin
    buf_clock = sync_b[3] & ~sync_b[2];
    src_clock = USE_MANAGER ? buf_clock : sync_b[1];
    reset_level = RESET_ACTIVE_LOW ? ~sync_b[4] : sync_b[4];
  end

  ////////////////////////////////////////////////////////////////////////
  // The manager model declares lock after a run of clock edges.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_clock_prev <= 1'b0;
      edge_count <= 5'h00;
      locked <= 1'b0;
    end else begin
      buf_clock_prev <= src_clock;
      if (USE_MANAGER) begin
        if (src_clock & ~buf_clock_prev &&
            edge_count != 5'(memsys_pkg::LOCK_EDGES)) begin
          edge_count <= edge_count + 5'h01;
        end
        locked <= (edge_count == 5'(memsys_pkg::LOCK_EDGES));
      end else begin
        locked <= sync_b[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working clock and its inverse, both from flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_clock <= 1'b0;
      work_clock_n <= 1'b1;
    end else begin
      work_clock <= src_clock;
      work_clock_n <= ~src_clock;
    end
  end

  // Internal reset stays on until lock is seen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_reset <= 1'b1;
    end else begin
      int_reset <= reset_level | ~locked;
    end
  end

endmodule : clock_reset_gen

/* rtl/memsys_pkg.sv */
// Shared constants of the memory system interface block.
// Assumes a 20 MHz system clock and an 8-bit register port.
package memsys_pkg;

  // Clock period and derived timing counts.
  localparam int CLK_PERIOD_NS = 50;
  localparam int INIT_WAIT_NS = 200000;
  localparam int INIT_WAIT_CYCLES =
    (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_EDGES = 16;

  // Widths of the register port and of the memory data path.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;

  // Register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] REG_WRITE_DATA = 4'h5;
  localparam logic [3:0] REG_READ_DATA = 4'h6;

  // Control register bits; init and read are self-clearing commands, test arms the self-test until an internal reset.
  localparam int CTRL_INIT = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_TEST = 2;

  // Status register bits.
  localparam int ST_INIT = 0;
  localparam int ST_VALID = 1;
  localparam int ST_MISMATCH = 2;
  localparam int ST_LOCK = 3;

  // Interrupt event bits.
  localparam int IRQ_INIT = 0;
  localparam int IRQ_VALID = 1;
  localparam int IRQ_MISMATCH = 2;
  localparam int IRQ_UNLOCK = 3;

  // Memory command codes as RAS, CAS, WE levels.
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [IRQ_W-1:0] RESET_IRQ = 4'h0;

endpackage : memsys_pkg

/* rtl/memsys_top.sv */
// Memory system interface top: register port, init sequence, write
// stage, read capture with loopback strobe reset, interrupts.
// Assumes pins are asynchronous to CLK; the register port is not.
//
// What this block does
// - Reset input active low unless parameter cleared.
// - Read-valid high while read FIFO holds data.
// - Self-test flags error on differing read data.
// - Init-complete rises after power-up sequence ends.
// - Write data and enable registered together.
// - Read logic uses looped-back strobe divider reset.
// - Strobe complement and module reset are optional.
// - Manager fed by buffered differential system clock.
// - Working clock and inverted clock both produced.
// - Mismatch output only in self-test builds.
// - Internal resets held until clock lock.
`timescale 1ns/1ps
module memsys_top #(
  parameter bit USE_MANAGER = 1'b1,
  parameter bit RESET_ACTIVE_LOW = 1'b1,
  parameter bit SELF_TEST = 1'b1,
  parameter bit DIFF_STROBE = 1'b1,
  parameter bit REG_DIMM = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SYS_RESET_IN,
  input wire logic SYS_CLOCK_POS,
  input wire logic SYS_CLOCK_NEG,
  input wire logic EXT_CLOCK,
  input wire logic EXT_LOCK,
  input wire logic [memsys_pkg::ADDR_W-1:0] ADDR,
  input wire logic [memsys_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [memsys_pkg::DATA_W-1:0] RDATA,
  output logic IRQ,
  output logic READ_VALID_OUT,
  output logic INIT_COMPLETE_OUT,
  output logic MISMATCH_ERROR_OUT,
  output logic WORK_CLOCK_OUT,
  output logic WORK_CLOCK_N_OUT,
  output logic STROBE_DIV_RESET_DRIVE,
  input wire logic STROBE_DIV_RESET_RETURN,
  output logic [2:0] MEM_CMD,
  output logic MEM_CKE,
  output logic MEM_WRITE_EN,
  output logic [memsys_pkg::DATA_W-1:0] MEM_DQ_OUT,
  output logic MEM_DQ_OE,
  input wire logic [memsys_pkg::DATA_W-1:0] MEM_DQ_IN,
  output logic MEM_STROBE_OUT,
  output logic MEM_STROBE_COMPLEMENT_OUT,
  output logic MEM_STROBE_OE,
  output logic MEM_MODULE_RESET
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Init sequence states, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_WAIT = 5'h02,
    S_PRECHARGE = 5'h04,
    S_MODE = 5'h08,
    S_DONE = 5'h10
  } init_e;

  init_e init_state; // Current init step.
  logic [12:0] wait_count; // Power-up wait counter.
  logic locked; // Clock lock from the generator.
  logic soft_reset; // Lock-gated internal reset.
  logic lock_prev; // Lock level one cycle ago.
  logic test_enable; // Self-test compare armed.
  logic read_pending; // A read waits for the loopback.
  logic [1:0] ret_sync; // Loopback synchroniser.
  logic ret_prev; // Loopback level one cycle ago.
  logic [memsys_pkg::DATA_W-1:0] dq_sync_a; // Data pin first stage.
  logic [memsys_pkg::DATA_W-1:0] dq_sync_b; // Data pin second stage.
  logic [memsys_pkg::DATA_W-1:0] fifo_mem [memsys_pkg::FIFO_DEPTH];
  logic [memsys_pkg::PTR_W:0] fifo_count; // Words held.
  logic [memsys_pkg::PTR_W-1:0] wr_ptr; // Next slot to fill.
  logic [memsys_pkg::PTR_W-1:0] rd_ptr; // Oldest word.
  logic [memsys_pkg::IRQ_W-1:0] irq_status; // Sticky events.
  logic [memsys_pkg::IRQ_W-1:0] irq_enable; // Event mask.
  logic [memsys_pkg::IRQ_W-1:0] irq_event; // Events this cycle.
  logic mismatch_prev; // Mismatch level one cycle ago.

  // Decoded strobes of the register port.
  logic ctrl_wr;
  logic data_wr;
  logic data_rd;
  logic capture;
  logic fifo_push;
  logic fifo_pop;
  logic mismatch;

  selftest_if test_link ();

  ////////////////////////////////////////////////////////////////////////
  // Clock and reset generation.
  clock_reset_gen #(
    .USE_MANAGER(USE_MANAGER),
    .RESET_ACTIVE_LOW(RESET_ACTIVE_LOW)
  ) u_clock_reset (
    .clk(CLK),
    .rst(RST),
    .sys_reset_in(SYS_RESET_IN),
    .sys_clock_pos(SYS_CLOCK_POS),
    .sys_clock_neg(SYS_CLOCK_NEG),
    .ext_clock(EXT_CLOCK),
    .ext_lock(EXT_LOCK),
    .work_clock(WORK_CLOCK_OUT),
    .work_clock_n(WORK_CLOCK_N_OUT),
    .locked(locked),
    .int_reset(soft_reset)
  );

  // Decode register port strobes; a write command is refused until the
  // memory has been initialised, since the pins are not yet live.
  always_comb begin
    ctrl_wr = WR && ADDR == memsys_pkg::REG_CTRL;
    data_wr = WR && ADDR == memsys_pkg::REG_WRITE_DATA &&
      init_state == S_DONE;
    data_rd = RD && ADDR == memsys_pkg::REG_READ_DATA;
    fifo_pop = data_rd && fifo_count != '0;
    capture = read_pending && ret_sync[1] && !ret_prev;
    fifo_push = capture && fifo_count != 3'(memsys_pkg::FIFO_DEPTH);
  end

  ////////////////////////////////////////////////////////////////////////
  // Initialisation sequence: wait, precharge, load mode, done.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      init_state <= S_IDLE;
      wait_count <= 13'h0000;
    end else if (soft_reset) begin
      init_state <= S_IDLE;
      wait_count <= 13'h0000;
    end else begin
      unique case (init_state)
        S_IDLE: begin
          // Sequence starts only on the software command.
          if (ctrl_wr && WDATA[memsys_pkg::CTRL_INIT]) begin
            init_state <= S_WAIT;
            wait_count <= 13'h0000;
          end
        end
        S_WAIT: begin
          // Power-up wait before the first command.
          if (wait_count == 13'(memsys_pkg::INIT_WAIT_CYCLES - 1)) begin
            init_state <= S_PRECHARGE;
          end else begin
            wait_count <= wait_count + 13'h0001;
          end
        end
        S_PRECHARGE: begin
          init_state <= S_MODE;
        end
        S_MODE: begin
          init_state <= S_DONE;
        end
        S_DONE: begin
          init_state <= S_DONE;
        end
      endcase
    end
  end

  // Init-complete and clock enable follow the sequence.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INIT_COMPLETE_OUT <= 1'b0;
      MEM_CKE <= 1'b0;
    end else begin
      INIT_COMPLETE_OUT <= init_state == S_DONE;
      MEM_CKE <= init_state != S_IDLE && init_state != S_WAIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write stage: command, data, enable and strobe leave in one flop
  // stage so the board sees them aligned.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM_CMD <= memsys_pkg::CMD_NOP;
      MEM_DQ_OUT <= memsys_pkg::RESET_BYTE;
      MEM_DQ_OE <= 1'b0;
      MEM_WRITE_EN <= 1'b0;
      MEM_STROBE_OUT <= 1'b0;
      MEM_STROBE_OE <= 1'b0;
    end else begin
      MEM_CMD <= memsys_pkg::CMD_NOP;
      MEM_DQ_OE <= data_wr;
      MEM_WRITE_EN <= data_wr;
      MEM_STROBE_OUT <= data_wr;
      MEM_STROBE_OE <= data_wr;
      if (data_wr) begin
        MEM_DQ_OUT <= WDATA;
        MEM_CMD <= memsys_pkg::CMD_WRITE;
      end else if (init_state == S_PRECHARGE) begin
        MEM_CMD <= memsys_pkg::CMD_PRECHARGE;
      end else if (init_state == S_MODE) begin
        MEM_CMD <= memsys_pkg::CMD_LOAD_MODE;
      end else if (ctrl_wr && WDATA[memsys_pkg::CTRL_READ] &&
                   init_state == S_DONE) begin
        MEM_CMD <= memsys_pkg::CMD_READ;
      end
    end
  end

  // Optional pins are tied low when absent; the complement idles high.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM_STROBE_COMPLEMENT_OUT <= DIFF_STROBE;
      MEM_MODULE_RESET <= 1'b0;
    end else begin
      MEM_STROBE_COMPLEMENT_OUT <= DIFF_STROBE & ~data_wr;
      MEM_MODULE_RESET <= REG_DIMM & ~soft_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read issue: drive the divider reset out and wait for it to return.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      STROBE_DIV_RESET_DRIVE <= 1'b0;
      read_pending <= 1'b0;
    end else if (soft_reset) begin
      STROBE_DIV_RESET_DRIVE <= 1'b0;
      read_pending <= 1'b0;
    end else begin
      STROBE_DIV_RESET_DRIVE <= ctrl_wr && WDATA[memsys_pkg::CTRL_READ]
        && init_state == S_DONE;
      if (STROBE_DIV_RESET_DRIVE) begin
        read_pending <= 1'b1;
      end else if (capture) begin
        read_pending <= 1'b0;
      end
    end
  end

  // Loopback and data pins are asynchronous and pass two flops.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ret_sync <= 2'h0;
      ret_prev <= 1'b0;
      dq_sync_a <= memsys_pkg::RESET_BYTE;
      dq_sync_b <= memsys_pkg::RESET_BYTE;
    end else begin
      ret_sync <= {ret_sync[0], STROBE_DIV_RESET_RETURN};
      ret_prev <= ret_sync[1];
      dq_sync_a <= MEM_DQ_IN;
      dq_sync_b <= dq_sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read FIFO in flops; a capture into a full FIFO is dropped.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
    end else if (soft_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
    end else begin
      if (fifo_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_count <= fifo_count + 3'h1;
      end else if (fifo_pop && !fifo_push) begin
        fifo_count <= fifo_count - 3'h1;
      end
    end
  end

  // One storage slot per entry.
  for (genvar i = 0; i < memsys_pkg::FIFO_DEPTH; i++) begin : g_slot
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        fifo_mem[i] <= memsys_pkg::RESET_BYTE;
      end else if (fifo_push && wr_ptr == 2'(i)) begin
        fifo_mem[i] <= dq_sync_b;
      end
    end
  end

  // Read-valid follows the FIFO occupancy.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      READ_VALID_OUT <= 1'b0;
    end else begin
      READ_VALID_OUT <= (fifo_count != '0 || fifo_push) &&
        !(fifo_pop && fifo_count == 3'h1 && !fifo_push);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-test: armed by software, compares each captured word.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      test_enable <= 1'b0;
    end else if (soft_reset) begin
      test_enable <= 1'b0;
    end else if (ctrl_wr && WDATA[memsys_pkg::CTRL_TEST]) begin
      test_enable <= SELF_TEST;
    end
  end

  always_comb begin
    test_link.expect_load = data_wr;
    test_link.expect_data = WDATA;
    test_link.capture = fifo_push;
    test_link.capture_data = dq_sync_b;
  end

  if (SELF_TEST) begin : g_test
    selftest_check u_check (
      .clk(CLK),
      .rst(RST),
      .soft_reset(soft_reset),
      .enable(test_enable),
      .link(test_link.check)
    );
  end else begin : g_no_test
    assign test_link.mismatch = 1'b0;
  end

  assign mismatch = test_link.mismatch;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MISMATCH_ERROR_OUT <= 1'b0;
      mismatch_prev <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      MISMATCH_ERROR_OUT <= mismatch;
      mismatch_prev <= mismatch;
      lock_prev <= locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, set wins over a clear in the same cycle.
  always_comb begin
    irq_event = '0;
    irq_event[memsys_pkg::IRQ_INIT] = init_state == S_MODE;
    irq_event[memsys_pkg::IRQ_VALID] = fifo_push;
    irq_event[memsys_pkg::IRQ_MISMATCH] = mismatch & ~mismatch_prev;
    irq_event[memsys_pkg::IRQ_UNLOCK] = lock_prev & ~locked;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_status <= memsys_pkg::RESET_IRQ;
      irq_enable <= memsys_pkg::RESET_IRQ;
    end else begin
      if (WR && ADDR == memsys_pkg::REG_IRQ_ENABLE) begin
        irq_enable <= WDATA[memsys_pkg::IRQ_W-1:0];
      end
      if (WR && ADDR == memsys_pkg::REG_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~WDATA[memsys_pkg::IRQ_W-1:0]) |
          irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read: data stand in the cycle after the strobe only.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= memsys_pkg::RESET_BYTE;
    end else begin
      RDATA <= memsys_pkg::RESET_BYTE;
      if (RD) begin
        unique case (ADDR)
          memsys_pkg::REG_STATUS: begin
            RDATA[memsys_pkg::ST_INIT] <= init_state == S_DONE;
            RDATA[memsys_pkg::ST_VALID] <= fifo_count != '0;
            RDATA[memsys_pkg::ST_MISMATCH] <= mismatch;
            RDATA[memsys_pkg::ST_LOCK] <= locked;
          end
          memsys_pkg::REG_IRQ_STATUS: begin
            RDATA[memsys_pkg::IRQ_W-1:0] <= irq_status;
          end
          memsys_pkg::REG_IRQ_ENABLE: begin
            RDATA[memsys_pkg::IRQ_W-1:0] <= irq_enable;
          end
          memsys_pkg::REG_READ_DATA: begin
            if (fifo_count != '0) begin
              RDATA <= fifo_mem[rd_ptr];
            end
          end
          default: begin
            RDATA <= memsys_pkg::RESET_BYTE;
          end
        endcase
      end
    end
  end

endmodule : memsys_top

/* rtl/selftest_check.sv */
// Self-test checker: compares returned read data with written data.
// Assumes capture pulses come with a valid word from the read path.
`timescale 1ns/1ps
module selftest_check (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic enable,
  selftest_if.check link
);

  logic [memsys_pkg::DATA_W-1:0] expected; // Last value written.

  ////////////////////////////////////////////////////////////////////////
  // Record the written value and flag any differing read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expected <= memsys_pkg::RESET_BYTE;
      link.mismatch <= 1'b0;
    end else if (soft_reset) begin
      expected <= memsys_pkg::RESET_BYTE;
      link.mismatch <= 1'b0;
    end else begin
      if (link.expect_load) begin
        expected <= link.expect_data;
      end
      if (enable && link.capture && link.capture_data != expected) begin
        link.mismatch <= 1'b1;
      end
    end
  end

endmodule : selftest_check

/* rtl/selftest_if.sv */
// Carrier between the main block and its self-test checker.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface selftest_if;
  logic expect_load; // Pulse: a new written value is recorded.
  logic [memsys_pkg::DATA_W-1:0] expect_data; // Value written.
  logic capture; // Pulse: a read word was captured.
  logic [memsys_pkg::DATA_W-1:0] capture_data; // Word returned.
  logic mismatch; // Sticky mismatch flag from the checker.
  modport source (output expect_load, expect_data, capture,
    capture_data, input mismatch);
  modport check (input expect_load, expect_data, capture,
    capture_data, output mismatch);
endinterface : selftest_if
